// File: hw/drb_burst.sv
// Operation
// - rising edge, CS low, CA0 high, CA1 low: access
// - start column from CA5r-CA6r and CA1f-CA9f
// - read data RL clocks after command edge
// - strobe preamble low, data on each strobe edge
// - read latency taken from mode setting
// - seamless reads every 2, 4, 8 clocks
// - interrupted burst length is twice command spacing
// - device samples write data on strobe edges
// - seamless writes every 2, 4, 8 clocks
`timescale 1ns/1ps
`default_nettype none
module drb_burst
  import drb_pkg::*;
(
  input  wire logic                        core_clk_in,
  input  wire logic                        sys_rst_in,
  input  wire logic                        ck_in,
  input  wire logic                        cs_n_in,
  input  wire logic [drb_pkg::CA_W-1:0]    ca_in,
  input  wire logic [drb_pkg::MODE_W-1:0]  rl_in,
  input  wire logic [drb_pkg::MODE_W-1:0]  wl_in,
  input  wire logic [drb_pkg::BLSEL_W-1:0] bl_in,
  input  wire logic                        dqs_in,
  input  wire logic [drb_pkg::DQ_W-1:0]    dq_in,
  output logic                             dqs_out,
  output logic                             dqs_oe_n_out,
  output logic [drb_pkg::DQ_W-1:0]         dq_out,
  output logic                             dq_oe_n_out,
  output logic [drb_pkg::DQ_W-1:0]         wr_data_out,
  output logic                             wr_valid_out,
  input  wire logic                        wr_ready_in,
  output logic                             wr_overrun_out
);
  import drb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic                ck_s1, ck_s2, ck_d;
  logic                cs_n_s1, cs_n_s2;
  logic [CA_W-1:0]     ca_s1, ca_s2;
  logic                dqs_s1, dqs_s2, dqs_d;
  logic [DQ_W-1:0]     dq_s1, dq_s2;
  logic [MODE_W-1:0]   rl_s1, rl_q, wl_s1, wl_q;
  logic [BLSEL_W-1:0]  bl_s1, bl_q;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ck_s1   <= 1'b0;
      ck_s2   <= 1'b0;
      ck_d    <= 1'b0;
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      ca_s1   <= '0;
      ca_s2   <= '0;
      dqs_s1  <= 1'b0;
      dqs_s2  <= 1'b0;
      dqs_d   <= 1'b0;
      dq_s1   <= '0;
      dq_s2   <= '0;
      rl_s1   <= '0;
      rl_q    <= '0;
      wl_s1   <= '0;
      wl_q    <= '0;
      bl_s1   <= '0;
      bl_q    <= '0;
    end else begin
      ck_s1   <= ck_in;
      ck_s2   <= ck_s1;
      ck_d    <= ck_s2;
      cs_n_s1 <= cs_n_in;
      cs_n_s2 <= cs_n_s1;
      ca_s1   <= ca_in;
      ca_s2   <= ca_s1;
      dqs_s1  <= dqs_in;
      dqs_s2  <= dqs_s1;
      dqs_d   <= dqs_s2;
      dq_s1   <= dq_in;
      dq_s2   <= dq_s1;
      rl_s1   <= rl_in;
      rl_q    <= rl_s1;
      wl_s1   <= wl_in;
      wl_q    <= wl_s1;
      bl_s1   <= bl_in;
      bl_q    <= bl_s1;
    end
  end

  logic ck_rise, ck_fall, ck_edge, dqs_edge;
  assign ck_rise  = ck_s2 & ~ck_d;
  assign ck_fall  = ~ck_s2 & ck_d;
  assign ck_edge  = ck_rise | ck_fall;
  assign dqs_edge = dqs_s2 ^ dqs_d;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  function automatic logic [TAP_W-1:0] lat_tap(input logic [MODE_W-1:0] lat);
    if (lat == '0) begin
      return '0;
    end else if (lat > MODE_W'(LINE_D)) begin
      return TAP_W'(LINE_D - 1);
    end else begin
      return TAP_W'(lat - 1'b1);
    end
  endfunction

  logic [TAP_W-1:0]  rl_tap, wl_tap;
  logic [BEAT_W-1:0] bl_beats;
  assign rl_tap = lat_tap(rl_q);
  assign wl_tap = lat_tap(wl_q);
  assign bl_beats = (bl_q == BLSEL_4) ? BEATS_4 :
                    (bl_q == BLSEL_8) ? BEATS_8 : BEATS_16;

  ////////////////////////////////////////////////////////////////////////////
  // column access capture
  logic       col_cmd;
  logic       cmd_v, cmd_rd;
  logic [1:0] col_lo;
  assign col_cmd = ~cs_n_s2 & ca_s2[CA_ACC_HI] & ~ca_s2[CA_ACC_LO];

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd_v  <= 1'b0;
      cmd_rd <= 1'b0;
      col_lo <= '0;
    end else if (ck_rise) begin
      cmd_v  <= col_cmd;
      cmd_rd <= ca_s2[CA_RD_SEL];
      col_lo <= ca_s2[CA_COLR_HI:CA_COLR_LO];
    end else if (ck_fall) begin
      cmd_v  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latency line: entry k holds a command issued k link clocks ago
  logic             line_v   [LINE_D];
  logic             line_rd  [LINE_D];
  logic [COL_W-1:0] line_col [LINE_D];

  for (genvar i = 0; i < LINE_D; i++) begin : g_line
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        line_v[i]   <= 1'b0;
        line_rd[i]  <= 1'b0;
        line_col[i] <= '0;
      end else if (i == 0) begin
        if (ck_fall && cmd_v) begin
          line_v[i]   <= 1'b1;
          line_rd[i]  <= cmd_rd;
          line_col[i] <= {ca_s2[CA_COLF_HI:CA_COLF_LO], col_lo};
        end else if (ck_rise) begin
          line_v[i]   <= 1'b0;
        end
      end else if (ck_rise) begin
        line_v[i]   <= line_v[(i == 0) ? 0 : i - 1];
        line_rd[i]  <= line_rd[(i == 0) ? 0 : i - 1];
        line_col[i] <= line_col[(i == 0) ? 0 : i - 1];
      end
    end
  end

  logic rd_due, wr_due, fire_rd, fire_wr;
  assign rd_due  = line_v[rl_tap] & line_rd[rl_tap];
  assign wr_due  = line_v[wl_tap] & ~line_rd[wl_tap];
  assign fire_rd = ck_rise & rd_due;
  assign fire_wr = ck_rise & wr_due;

  ////////////////////////////////////////////////////////////////////////////
  // storage array
  logic [DQ_W-1:0]   mem [MEM_DEPTH];
  logic [MEM_AW-1:0] rd_col, wr_col;
  assign rd_col = line_col[rl_tap][MEM_AW-1:0];
  assign wr_col = line_col[wl_tap][MEM_AW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // read burst driver
  logic [BEAT_W-1:0] rd_left;
  logic [MEM_AW-1:0] rd_addr;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_left      <= '0;
      rd_addr      <= '0;
      dqs_out      <= 1'b0;
      dqs_oe_n_out <= 1'b1;
      dq_out       <= '0;
      dq_oe_n_out  <= 1'b1;
    end else if (fire_rd) begin
      // a new read replaces any burst still running
      dqs_out      <= 1'b1;
      dqs_oe_n_out <= 1'b0;
      dq_out       <= mem[rd_col];
      dq_oe_n_out  <= 1'b0;
      rd_addr      <= rd_col + 1'b1;
      rd_left      <= bl_beats - 1'b1;
    end else if (ck_edge && rd_left != '0) begin
      dqs_out      <= ~dqs_out;
      dq_out       <= mem[rd_addr];
      rd_addr      <= rd_addr + 1'b1;
      rd_left      <= rd_left - 1'b1;
    end else if (ck_fall && rd_due) begin
      dqs_out      <= 1'b0;
      dqs_oe_n_out <= 1'b0;
      dq_oe_n_out  <= 1'b1;
    end else if (ck_edge) begin
      dqs_out      <= 1'b0;
      dqs_oe_n_out <= 1'b1;
      dq_oe_n_out  <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write burst capture
  logic [BEAT_W-1:0] wr_left;
  logic [MEM_AW-1:0] wr_addr;
  logic              wr_beat;
  assign wr_beat = dqs_edge & (wr_left != '0) & ~fire_wr;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_left <= '0;
      wr_addr <= '0;
    end else if (fire_wr) begin
      wr_left <= bl_beats;
      wr_addr <= wr_col;
    end else if (wr_beat) begin
      wr_left <= wr_left - 1'b1;
      wr_addr <= wr_addr + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (wr_beat) begin
      mem[wr_addr] <= dq_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer toward the user side
  logic [DQ_W-1:0] spare;
  logic            spare_v, pop, buf_ready, push;
  assign pop       = wr_valid_out & wr_ready_in;
  assign buf_ready = ~(wr_valid_out & spare_v) | pop;
  assign push      = wr_beat & buf_ready;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_data_out  <= '0;
      wr_valid_out <= 1'b0;
      spare        <= '0;
      spare_v      <= 1'b0;
    end else if (pop) begin
      if (spare_v) begin
        wr_data_out <= spare;
        if (push) begin
          spare   <= dq_s2;
        end else begin
          spare_v <= 1'b0;
        end
      end else if (push) begin
        wr_data_out  <= dq_s2;
      end else begin
        wr_valid_out <= 1'b0;
      end
    end else if (push) begin
      if (!wr_valid_out) begin
        wr_data_out  <= dq_s2;
        wr_valid_out <= 1'b1;
      end else begin
        spare   <= dq_s2;
        spare_v <= 1'b1;
      end
    end
  end

  // a beat that finds the buffer full is dropped and flagged
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_overrun_out <= 1'b0;
    end else if (wr_beat && !buf_ready) begin
      wr_overrun_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_cmd_decode: assert property (
    ck_rise && col_cmd |=> cmd_v && cmd_rd == $past(ca_s2[CA_RD_SEL]))
    else $error("column access not decoded");

  chk_col_capture: assert property (
    ck_fall && cmd_v |=> line_v[0] &&
      line_col[0] == {$past(ca_s2[CA_COLF_HI:CA_COLF_LO]), $past(col_lo)})
    else $error("start column not assembled");

  chk_read_latency: assert property (
    fire_rd |=> dqs_out && !dqs_oe_n_out && !dq_oe_n_out)
    else $error("read data not driven at latency");

  chk_latency_tap: assert property (
    ck_rise && line_v[rl_tap] && line_rd[rl_tap] |=> !dq_oe_n_out)
    else $error("read latency not from mode setting");

  chk_read_preamble: assert property (
    ck_fall && rd_due && rd_left == '0 |=> !dqs_oe_n_out && !dqs_out && dq_oe_n_out)
    else $error("read preamble missing");

  chk_strobe_toggle: assert property (
    ck_edge && !fire_rd && rd_left != '0 |=> dqs_out != $past(dqs_out) && !dq_oe_n_out)
    else $error("strobe did not toggle per beat");

  chk_interrupt_len: assert property (
    fire_rd |=> rd_left == $past(bl_beats) - 1'b1)
    else $error("read burst length wrong after start");

  chk_write_count: assert property (
    wr_beat |=> wr_left == $past(wr_left) - 1'b1 ##0 wr_addr == $past(wr_addr) + 1'b1)
    else $error("write beat not counted");

  chk_write_stop: assert property (
    wr_left == '0 && !fire_wr |=> $stable(wr_addr))
    else $error("write capture beyond burst");

  chk_buf_hold: assert property (
    wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_data_out))
    else $error("buffer output changed while stalled");

  cov_read_burst: cover property (fire_rd ##[1:300] (ck_edge && rd_left == 5'h01));
  cov_seamless_rd: cover property (ck_fall && rd_left == 5'h01 ##[1:20] fire_rd);
  cov_write_burst: cover property (fire_wr ##[1:400] (wr_beat && wr_left == 5'h01));
  cov_buf_full: cover property (wr_valid_out && spare_v);
endmodule
`default_nettype wire

// File: include/drb_pkg.sv
`default_nettype none
package drb_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // pin widths
  localparam int DQ_W      = 8;
  localparam int CA_W      = 10;
  localparam int COL_W     = 11;
  localparam int MODE_W    = 4;
  localparam int BLSEL_W   = 2;
  localparam int BEAT_W    = 5;

  ////////////////////////////////////////////////////////////////////////////
  // command/address bit positions
  localparam int CA_ACC_HI  = 0;
  localparam int CA_ACC_LO  = 1;
  localparam int CA_RD_SEL  = 2;
  localparam int CA_COLR_LO = 5;
  localparam int CA_COLR_HI = 6;
  localparam int CA_COLF_LO = 1;
  localparam int CA_COLF_HI = 9;

  ////////////////////////////////////////////////////////////////////////////
  // burst length select and beats
  localparam logic [BLSEL_W-1:0] BLSEL_4  = 2'h0;
  localparam logic [BLSEL_W-1:0] BLSEL_8  = 2'h1;
  localparam logic [BEAT_W-1:0]  BEATS_4  = 5'h04;
  localparam logic [BEAT_W-1:0]  BEATS_8  = 5'h08;
  localparam logic [BEAT_W-1:0]  BEATS_16 = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // latency pipeline and storage
  localparam int LINE_D    = 8;
  localparam int TAP_W     = 3;
  localparam int MEM_AW    = 6;
  localparam int MEM_DEPTH = 64;

  ////////////////////////////////////////////////////////////////////////////
  // clocks: core 25 ns, link 200 ns
  localparam int CORE_CK_NS = 25;
  localparam int LINK_CK_NS = 200;
  localparam int LINK_RATIO = LINK_CK_NS / CORE_CK_NS;
endpackage
`default_nettype wire

// File: tb/drb_host.sv
`timescale 1ns/1ps
`default_nettype none
module drb_host
  import drb_pkg::*;
(
  input  wire logic                rst_in,
  output logic                     ck_out,
  output logic                     cs_n_out,
  output logic [drb_pkg::CA_W-1:0] ca_out,
  output logic                     dqs_out,
  output logic [drb_pkg::DQ_W-1:0] dq_out
);
  int rcnt = 0;
  int hcnt = 0;
  // link clock runs free once out of reset; hcnt moves mid half-period
  initial begin
    ck_out = 1'b0;
    cs_n_out = 1'b1;
    ca_out = 10'h0;
    dqs_out = 1'b0;
    dq_out = 8'h0;
    wait (!rst_in);
    #100;
    forever begin
      #50;
      rcnt += int'(!ck_out);
      ck_out = ~ck_out;
      #50 hcnt++;
    end
  end
  ////////////////////////////////////////////////////////////
  // bus changes a quarter link period after each edge, so the device's
  // synchronisers never see the new value at the edge that samples the old
  task automatic cmd(input logic rd, input logic acc, output int c,
                     input logic [COL_W-1:0] col);
    @(negedge ck_out);
    #50;
    cs_n_out = 1'b0;
    ca_out = {3'h0, col[1:0], 2'h0, rd, ~acc, acc};
    @(posedge ck_out);
    c = rcnt;
    #50;
    ca_out = {col[10:2], 1'b0};
    @(negedge ck_out);
    #50;
    cs_n_out = 1'b1;
    ca_out = ~ca_out;
  endtask
  // strobe starts low, data held 80 ns past each edge then scrambled
  task automatic wdat(input int t, input logic [DQ_W-1:0] d[$]);
    wait (rcnt >= t);
    #40;
    foreach (d[i]) begin
      dq_out = d[i];
      #10 dqs_out = ~dqs_out;
      #80 dq_out = ~d[i];
      #10;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/tb_ddr_read_write_burst.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_read_write_burst;
  import drb_pkg::*;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               rdy = 1'b0;
  logic               stall = 1'b0;
  logic               dqs_q = 1'b0;
  logic [2:0]         pre = 3'h7;
  logic [MODE_W-1:0]  rl_v = 4'h3;
  logic [MODE_W-1:0]  wl_v = 4'h1;
  logic [BLSEL_W-1:0] bl_v = 2'h0;
  logic [DQ_W-1:0]    mem [MEM_DEPTH];
  logic [DQ_W-1:0]    rq[$];
  logic [DQ_W-1:0]    wq[$];
  int                 tq[$];
  int                 rl = 3;
  int                 wl = 1;
  int                 error_cnt = 0;
  int                 checks_done = 0;
  wire                ck, cs_n, h_dqs, dqs, dqs_o, dqs_oe_n, dq_oe_n, wvalid, ovr;
  wire [CA_W-1:0]     ca;
  wire [DQ_W-1:0]     h_dq, dq, dq_o, wdata;
  wire [20:0]         st = {dqs_o, dqs_oe_n, dq_o, dq_oe_n, wvalid, ovr, wdata};
  // shared pins: device drive wins while its enable is low
  assign dqs = dqs_oe_n ? h_dqs : dqs_o;
  assign dq = dq_oe_n ? h_dq : dq_o;

  drb_host i_host (.rst_in(rst), .ck_out(ck), .cs_n_out(cs_n), .ca_out(ca),
                   .dqs_out(h_dqs), .dq_out(h_dq));
  drb_burst i_dut (.core_clk_in(clk), .sys_rst_in(rst), .ck_in(ck), .cs_n_in(cs_n),
                   .ca_in(ca), .rl_in(rl_v), .wl_in(wl_v), .bl_in(bl_v), .dqs_in(dqs),
                   .dq_in(dq), .dqs_out(dqs_o), .dqs_oe_n_out(dqs_oe_n), .dq_out(dq_o),
                   .dq_oe_n_out(dq_oe_n), .wr_data_out(wdata), .wr_valid_out(wvalid),
                   .wr_ready_in(rdy), .wr_overrun_out(ovr));

  initial begin
    forever #(CORE_CK_NS / 2.0) clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rst_pulse();
    @(posedge clk);
    #2 rst = 1'b1;
    repeat (6) @(posedge clk);
    chk("reset state", {2'h1, 8'h0, 3'h4, 8'h0}, st);
    #2 rst = 1'b0;
  endtask
  task automatic set_mode(input int m);
    @(posedge clk);
    #2 bl_v = BLSEL_W'(m);
    rl = 3 + m;
    wl = 1 + m;
    rl_v = MODE_W'(rl);
    wl_v = MODE_W'(wl);
    repeat (4) @(posedge clk);
  endtask
  // wait out bursts; spacing covers read/write turnaround
  task automatic drain();
    int n = 0;
    while ((rq.size() || wq.size() || dq_oe_n !== 1'b1) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n == 3000) begin
      chk("drain timeout", 21'h0, 21'h1);
      stop_test();
    end
    repeat (16) @(posedge clk);
  endtask
  // one column access; nb beats count for it
  task automatic go(input logic rd, input logic [COL_W-1:0] a, input int nb);
    int c;
    logic [DQ_W-1:0] d[$];
    logic [MEM_AW-1:0] k;
    i_host.cmd(rd, 1'b1, c, a);
    for (int i = 0; i < nb; i++) begin
      k = a[MEM_AW-1:0] + MEM_AW'(i);
      if (rd) begin
        rq.push_back(mem[k]);
        tq.push_back(2 * (c + rl) - 1 + i);
      end else begin
        mem[k] = DQ_W'($urandom);
        wq.push_back(mem[k]);
        d.push_back(mem[k]);
      end
    end
    if (!rd) fork
      i_host.wdat(c + wl, d);
    join_none
  endtask
  // second like access s clocks later: seamless or even interrupt
  task automatic pair(input logic rd, input logic [COL_W-1:0] a, input int s, input int nb);
    go(rd, a, 2 * s);
    repeat (s - 2) @(negedge ck);
    go(rd, a + 11'h20, nb);
    drain();
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (dqs_oe_n === 1'b0 && dqs_o !== dqs_q) begin
      chk("rd data", rq.size() ? rq.pop_front() : 'x, dq_o);
      chk("rd beat", tq.size() ? tq.pop_front() : -1, i_host.hcnt);
      chk("rd strobe", 4'h0, {pre, dq_oe_n});
    end
    dqs_q <= dqs_o;
    pre <= {pre[1:0], dqs_oe_n};
    if (wvalid === 1'b1 && rdy) begin
      chk("wr data", wq.size() ? wq.pop_front() : 'x, wdata);
    end
  end

  initial begin
    int c;
    int nb;
    logic [COL_W-1:0] a;
    void'($urandom(32'h08daa956));
    fork
      forever begin
        @(posedge clk);
        #2 rdy = stall ? 1'b0 : 1'(($urandom & 3) != 0);
      end
    join_none
    rst_pulse();
    set_mode(2);
    for (int k = 0; k < 4; k++) begin
      go(1'b0, COL_W'(16 * k), 16);
      drain();
    end
    for (int m = 0; m < 3; m++) begin
      set_mode(m);
      nb = 4 << m;
      a = COL_W'($urandom);
      for (int s = 2; s <= nb / 2; s *= 2) begin
        pair(1'b0, a, s, nb);
        go(1'b1, a, nb);
        drain();
        pair(1'b1, a, s, nb);
      end
    end
    chk("overrun", 21'h0, ovr);
    i_host.cmd(1'b1, 1'b0, c, 11'h0);
    repeat (100) @(posedge clk);
    set_mode(0);
    stall = 1'b1;
    go(1'b0, 11'h0, 4);
    repeat (60) @(posedge clk);
    void'(wq.pop_back());
    void'(wq.pop_back());
    stall = 1'b0;
    drain();
    chk("overrun", 21'h1, ovr);
    rst_pulse();
    stop_test();
  end
endmodule
`default_nettype wire
